// file: hdl/dim_map.svh
`ifndef DIM_MAP_SVH
`define DIM_MAP_SVH

// ==========================================================
// clock and time base
`define DIM_CLK_PERIOD_NS 100
`define DIM_TICK_NS       1000000
`define DIM_TICK_CYCLES   (`DIM_TICK_NS / `DIM_CLK_PERIOD_NS)

// ==========================================================
// data widths
`define DIM_POS_W  32
`define DIM_SPD_W  16
`define DIM_TIME_W 16
`define DIM_PCT_W  7
`define DIM_PCT_FULL 100

// ==========================================================
// synchronised pin positions
`define DIM_PIN_COUNT 6
`define DIM_PIN_POS   0
`define DIM_PIN_NEG   1
`define DIM_PIN_INC   2
`define DIM_PIN_SR    3
`define DIM_PIN_STOP  4
`define DIM_PIN_RST   5

`endif

// file: hdl/dim_pkg.sv
package dim_pkg;

    typedef enum logic [1:0] {DIR_IDLE, DIR_DELAY, DIR_ACTIVE} dim_dir_state_type;

    typedef enum logic [1:0] {
        INC_IDLE, INC_DELAY, INC_MONITOR, INC_STANDSTILL
    } dim_inc_state_type;

    typedef enum logic [1:0] {SR_IDLE, SR_DELAY, SR_MONITOR} dim_sr_state_type;

endpackage

// file: hdl/dim_input_sync.sv
`timescale 1ns/100ps
module dim_input_sync #(
    parameter int W = 6
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // raw pins
    input  wire logic [W-1:0] pinRaw,
    // synchronised view
    output logic      [W-1:0] pinLevel,
    output logic      [W-1:0] pinFall,
    output logic      [W-1:0] pinRise
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    // ==========================================================
    // two-flop synchroniser and previous sample
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= '1;
            sync_reg <= '1;
            prev_reg <= '1;
        end else begin
            meta_reg <= pinRaw;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign pinLevel = sync_reg;
    assign pinFall  = prev_reg & ~sync_reg;
    assign pinRise  = ~prev_reg & sync_reg;
endmodule

// file: hdl/dim_timer.sv
`timescale 1ns/100ps
module dim_timer #(
    parameter int TW = 16
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // control
    input  wire logic          tick,
    input  wire logic          load,
    input  wire logic [TW-1:0] loadValue,
    input  wire logic          clear,
    // status
    output logic               running,
    output logic               expired
);
    logic [TW-1:0] count_reg;
    logic [TW-1:0] count_next;
    logic          run_reg;
    logic          run_next;

    // ==========================================================
    // countdown in time-base ticks
    always_comb begin
        count_next = count_reg;
        run_next   = run_reg;
        if (load) begin
            count_next = loadValue;
            run_next   = 1'b1;
        end else if (clear) begin
            run_next = 1'b0;
        end else if (run_reg && tick && count_reg != '0) begin
            count_next = count_reg - TW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= '0;
            run_reg   <= 1'b0;
        end else begin
            count_reg <= count_next;
            run_reg   <= run_next;
        end
    end

    assign running = run_reg && count_reg != '0;
    assign expired = run_reg && count_reg == '0;
endmodule

// file: hdl/dim_monitor.sv
`timescale 1ns/100ps
`include "dim_map.svh"
module dim_monitor #(
    parameter int TICK_CYCLES = `DIM_TICK_CYCLES,
    parameter int POS_W       = `DIM_POS_W,
    parameter int SPD_W       = `DIM_SPD_W,
    parameter int TIME_W      = `DIM_TIME_W
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // activation pins, active low
    input  wire logic                positiveDirectionRequestN,
    input  wire logic                negativeDirectionRequestN,
    input  wire logic                incrementRequestN,
    input  wire logic                speedRangeRequestN,
    input  wire logic                rampStopRequestN,
    input  wire logic                integrityLevelResetIn,
    // encoder
    input  wire logic signed [POS_W-1:0] motorPosition,
    input  wire logic signed [SPD_W-1:0] motorSpeed,
    // delays and times, in time-base ticks
    input  wire logic [TIME_W-1:0]   directionDelay,
    input  wire logic [TIME_W-1:0]   incrementDelay,
    input  wire logic [TIME_W-1:0]   speedRangeDelay,
    input  wire logic [TIME_W-1:0]   standstillTime,
    input  wire logic [TIME_W-1:0]   toleranceTime,
    input  wire logic [TIME_W-1:0]   tolerancePeriod,
    // increment configuration
    input  wire logic [POS_W-1:0]    maxIncrement,
    input  wire logic [SPD_W-1:0]    incrementSpeedLimit,
    input  wire logic [SPD_W-1:0]    standstillLimit,
    input  wire logic [POS_W-1:0]    standstillWindow,
    input  wire logic                checkStandstill,
    input  wire logic                autoReactivate,
    input  wire logic                standstillWindowEn,
    // speed range configuration
    input  wire logic signed [SPD_W-1:0] speedMax,
    input  wire logic signed [SPD_W-1:0] speedMin,
    input  wire logic [`DIM_PCT_W-1:0]   tolerancePercent,
    input  wire logic                toleranceEn,
    // status
    output logic                     readyOut,
    output logic                     torqueOffAck,
    output logic                     brakingRampStop,
    output logic                     directionAck,
    output logic                     rangeAck,
    output logic                     standstillAck
);
    import dim_pkg::*;

    localparam int TCW = $clog2(TICK_CYCLES);

    // ==========================================================
    // helpers
    function automatic logic [SPD_W-1:0] absSpd(input logic signed [SPD_W-1:0] v);
        absSpd = v[SPD_W-1] ? SPD_W'(-v) : v;
    endfunction

    function automatic logic [POS_W-1:0] absDiff(input logic signed [POS_W-1:0] a,
                                                 input logic signed [POS_W-1:0] b);
        logic signed [POS_W-1:0] d;
        d = a - b;
        absDiff = d[POS_W-1] ? POS_W'(-d) : d;
    endfunction

    function automatic logic [SPD_W-1:0] tolBand(input logic [SPD_W-1:0] mag,
                                                 input logic [`DIM_PCT_W-1:0] pct);
        logic [SPD_W+`DIM_PCT_W-1:0] prod;
        prod = mag * pct;
        tolBand = SPD_W'(prod / `DIM_PCT_FULL);
    endfunction

    // ==========================================================
    // pin synchronisers
    logic [`DIM_PIN_COUNT-1:0] pinLevel;
    logic [`DIM_PIN_COUNT-1:0] pinFall;
    logic [`DIM_PIN_COUNT-1:0] pinRise;

    dim_input_sync #(.W(`DIM_PIN_COUNT)) uSync (
        .clk      (clk),
        .nrst     (nrst),
        .pinRaw   ({integrityLevelResetIn, rampStopRequestN, speedRangeRequestN,
                    incrementRequestN, negativeDirectionRequestN,
                    positiveDirectionRequestN}),
        .pinLevel (pinLevel),
        .pinFall  (pinFall),
        .pinRise  (pinRise)
    );

    logic posLow;
    logic negLow;
    logic incLow;
    logic srLow;
    assign posLow = !pinLevel[`DIM_PIN_POS];
    assign negLow = !pinLevel[`DIM_PIN_NEG];
    assign incLow = !pinLevel[`DIM_PIN_INC];
    assign srLow  = !pinLevel[`DIM_PIN_SR];

    // ==========================================================
    // time base
    logic [TCW-1:0] tickCnt_reg;
    logic [TCW-1:0] tickCnt_next;
    logic           tick;

    assign tick = tickCnt_reg == TCW'(TICK_CYCLES - 1);

    always_comb begin
        tickCnt_next = tick ? '0 : tickCnt_reg + TCW'(1);
    end

    // ==========================================================
    // timers
    logic dirLoad, dirExpired;
    logic incLoad, incExpired;
    logic srLoad, srExpired;
    logic tolTimeLoad, tolTimeClear, tolTimeRun, tolTimeExpired;
    logic tolPerLoad, tolPerClear, tolPerExpired;
    logic [TIME_W-1:0] incLoadVal;

    dim_timer #(.TW(TIME_W)) uDirTimer (
        .clk(clk), .nrst(nrst), .tick(tick), .load(dirLoad),
        .loadValue(directionDelay), .clear(1'b0),
        .running(), .expired(dirExpired));
    dim_timer #(.TW(TIME_W)) uIncTimer (
        .clk(clk), .nrst(nrst), .tick(tick), .load(incLoad),
        .loadValue(incLoadVal), .clear(1'b0),
        .running(), .expired(incExpired));
    dim_timer #(.TW(TIME_W)) uSrTimer (
        .clk(clk), .nrst(nrst), .tick(tick), .load(srLoad),
        .loadValue(speedRangeDelay), .clear(1'b0),
        .running(), .expired(srExpired));
    dim_timer #(.TW(TIME_W)) uTolTimer (
        .clk(clk), .nrst(nrst), .tick(tick), .load(tolTimeLoad),
        .loadValue(toleranceTime), .clear(tolTimeClear),
        .running(tolTimeRun), .expired(tolTimeExpired));
    dim_timer #(.TW(TIME_W)) uPerTimer (
        .clk(clk), .nrst(nrst), .tick(tick), .load(tolPerLoad),
        .loadValue(tolerancePeriod), .clear(tolPerClear),
        .running(), .expired(tolPerExpired));

    logic stop_reg;
    logic stop_next;

    // ==========================================================
    // direction monitor
    dim_dir_state_type dirState_reg, dirState_next;
    logic dirPos_reg, dirPos_next;
    logic dirViol;
    logic dirMonLow;

    assign dirMonLow = dirPos_reg ? posLow : negLow;

    always_comb begin
        dirState_next = dirState_reg;
        dirPos_next   = dirPos_reg;
        dirLoad       = 1'b0;
        dirViol       = 1'b0;
        if (pinFall[`DIM_PIN_POS] || pinFall[`DIM_PIN_NEG]) begin
            dirState_next = DIR_DELAY;
            dirPos_next   = pinFall[`DIM_PIN_POS];
            dirLoad       = 1'b1;
        end else begin
            case (dirState_reg)
                DIR_IDLE: ;
                DIR_DELAY: begin
                    if (!dirMonLow)
                        dirState_next = DIR_IDLE;
                    else if (dirExpired)
                        dirState_next = DIR_ACTIVE;
                end
                DIR_ACTIVE: begin
                    if (!dirMonLow)
                        dirState_next = DIR_IDLE;
                    else if (dirPos_reg ? motorSpeed < 0 : motorSpeed > 0)
                        dirViol = 1'b1;
                end
                default: dirState_next = DIR_IDLE;
            endcase
        end
        // old request may overlap only while the new delay runs
        if (posLow && negLow && dirState_next != DIR_DELAY)
            dirViol = 1'b1;
        if (stop_reg)
            dirState_next = DIR_IDLE;
    end

    // ==========================================================
    // increment monitor
    dim_inc_state_type incState_reg, incState_next;
    logic signed [POS_W-1:0] origin_reg, origin_next;
    logic [POS_W-1:0] travel;
    logic [SPD_W-1:0] speedMag;
    logic incViol;

    assign travel   = absDiff(motorPosition, origin_reg);
    assign speedMag = absSpd(motorSpeed);

    always_comb begin
        incState_next = incState_reg;
        origin_next   = origin_reg;
        incLoad       = 1'b0;
        incLoadVal    = incrementDelay;
        incViol       = 1'b0;
        if (pinFall[`DIM_PIN_INC]) begin
            incState_next = INC_DELAY;
            incLoad       = 1'b1;
            if (checkStandstill && speedMag > standstillLimit)
                incViol = 1'b1;
        end else begin
            case (incState_reg)
                INC_IDLE: ;
                INC_DELAY: begin
                    if (!incLow) begin
                        incState_next = INC_IDLE;
                    end else if (incExpired) begin
                        incState_next = INC_MONITOR;
                        origin_next   = motorPosition;
                    end
                end
                INC_MONITOR: begin
                    if (!incLow) begin
                        incState_next = INC_IDLE;
                    end else if (travel > maxIncrement || speedMag > incrementSpeedLimit) begin
                        incViol = 1'b1;
                    end else if (autoReactivate && travel != '0
                                 && speedMag <= standstillLimit) begin
                        incState_next = INC_STANDSTILL;
                        incLoad       = 1'b1;
                        incLoadVal    = standstillTime;
                        origin_next   = motorPosition;
                    end
                end
                INC_STANDSTILL: begin
                    if (!incLow) begin
                        incState_next = INC_IDLE;
                    end else if (standstillWindowEn && travel > standstillWindow) begin
                        incViol = 1'b1;
                    end else if (incExpired) begin
                        incState_next = INC_MONITOR;
                        origin_next   = motorPosition;
                    end
                end
                default: incState_next = INC_IDLE;
            endcase
        end
        if (stop_reg)
            incState_next = INC_IDLE;
    end

    // ==========================================================
    // speed range monitor with tolerance
    dim_sr_state_type srState_reg, srState_next;
    logic armed_reg, armed_next;
    logic srViol;
    logic outside;
    logic outTol;
    logic signed [SPD_W:0] tolHi;
    logic signed [SPD_W:0] tolLo;

    assign tolHi   = (SPD_W+1)'(speedMax) + (SPD_W+1)'({1'b0, tolBand(absSpd(speedMax),
                                                                 tolerancePercent)});
    assign tolLo   = (SPD_W+1)'(speedMin) - (SPD_W+1)'({1'b0, tolBand(absSpd(speedMin),
                                                                 tolerancePercent)});
    assign outside = motorSpeed > speedMax || motorSpeed < speedMin;
    assign outTol  = (SPD_W+1)'(motorSpeed) > tolHi || (SPD_W+1)'(motorSpeed) < tolLo;

    always_comb begin
        srState_next = srState_reg;
        armed_next   = armed_reg;
        srLoad       = 1'b0;
        srViol       = 1'b0;
        tolTimeLoad  = 1'b0;
        tolTimeClear = 1'b0;
        tolPerLoad   = 1'b0;
        tolPerClear  = 1'b0;
        if (pinFall[`DIM_PIN_SR]) begin
            srState_next = SR_DELAY;
            srLoad       = 1'b1;
            armed_next   = 1'b0;
            tolPerClear  = 1'b1;
            tolTimeClear = 1'b1;
        end else begin
            case (srState_reg)
                SR_IDLE: ;
                SR_DELAY: begin
                    if (!srLow)
                        srState_next = SR_IDLE;
                    else if (srExpired)
                        srState_next = SR_MONITOR;
                end
                SR_MONITOR: begin
                    if (!srLow) begin
                        srState_next = SR_IDLE;
                    end else if (!toleranceEn) begin
                        srViol = outside;
                    end else if (!armed_reg) begin
                        if (outside) begin
                            armed_next  = 1'b1;
                            tolPerLoad  = 1'b1;
                            tolTimeLoad = 1'b1;
                        end
                    end else begin
                        if (outTol || (outside && tolTimeExpired))
                            srViol = 1'b1;
                        if (!outside)
                            tolTimeClear = 1'b1;
                        else if (!tolTimeRun && !tolTimeExpired)
                            tolTimeLoad = 1'b1;
                        if (tolPerExpired && !outside) begin
                            armed_next  = 1'b0;
                            tolPerClear = 1'b1;
                        end
                    end
                end
                default: srState_next = SR_IDLE;
            endcase
        end
        if (stop_reg)
            srState_next = SR_IDLE;
    end

    // ==========================================================
    // braking ramp stop latch
    always_comb begin
        stop_next = stop_reg;
        if (pinRise[`DIM_PIN_RST] && pinLevel[`DIM_PIN_STOP])
            stop_next = 1'b0;
        // a violation in the clearing cycle still wins
        if (dirViol || incViol || srViol || !pinLevel[`DIM_PIN_STOP])
            stop_next = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tickCnt_reg  <= '0;
            dirState_reg <= DIR_IDLE;
            dirPos_reg   <= 1'b0;
            incState_reg <= INC_IDLE;
            origin_reg   <= '0;
            srState_reg  <= SR_IDLE;
            armed_reg    <= 1'b0;
            stop_reg     <= 1'b0;
        end else begin
            tickCnt_reg  <= tickCnt_next;
            dirState_reg <= dirState_next;
            dirPos_reg   <= dirPos_next;
            incState_reg <= incState_next;
            origin_reg   <= origin_next;
            srState_reg  <= srState_next;
            armed_reg    <= armed_next;
            stop_reg     <= stop_next;
        end
    end

    // ==========================================================
    // outputs
    assign brakingRampStop = stop_reg;
    assign readyOut        = !stop_reg;
    assign torqueOffAck    = stop_reg && speedMag <= standstillLimit;
    assign directionAck    = dirState_reg == DIR_ACTIVE;
    assign rangeAck        = incState_reg == INC_MONITOR
                             || srState_reg == SR_MONITOR;
    assign standstillAck   = incState_reg == INC_STANDSTILL;
endmodule

// file: dv/dim_monitor_sva.sv
`timescale 1ns/100ps
module dim_monitor_sva #(
    parameter int SPD_W  = 16,
    parameter int TIME_W = 16
) (
    // clock and reset
    input wire logic                    clk,
    input wire logic                    nrst,
    // activation pins
    input wire logic                    positiveDirectionRequestN,
    input wire logic                    negativeDirectionRequestN,
    input wire logic                    incrementRequestN,
    input wire logic                    speedRangeRequestN,
    // motion and configuration
    input wire logic signed [SPD_W-1:0] motorSpeed,
    input wire logic [TIME_W-1:0]       directionDelay,
    input wire logic [SPD_W-1:0]        incrementSpeedLimit,
    // status
    input wire logic                    readyOut,
    input wire logic                    torqueOffAck,
    input wire logic                    brakingRampStop,
    input wire logic                    directionAck,
    input wire logic                    rangeAck,
    input wire logic                    standstillAck
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // ====================
    // stop and status
    a_ready_follows_stop: assert property (readyOut == !brakingRampStop)
        else $error("ready wrong");
    a_torque_ack_stopped: assert property (torqueOffAck |-> brakingRampStop)
        else $error("torque ack wrong");
    a_stop_drops_acks: assert property ($rose(brakingRampStop) |=>
        !(directionAck || rangeAck || standstillAck)) else $error("ack kept during stop");

    // ====================
    // direction monitor
    a_both_dirs_stop: assert property ((!positiveDirectionRequestN
        && !negativeDirectionRequestN && directionDelay == '0)[*8] |-> ##[0:8] brakingRampStop)
        else $error("no stop on both");
    a_dir_no_early_ack: assert property (($fell(positiveDirectionRequestN)
        || $fell(negativeDirectionRequestN)) && directionDelay >= 16'h0002
        |-> ##4 !directionAck[*4]) else $error("early ack");
    a_dir_ack_bound: assert property ($fell(positiveDirectionRequestN)
        && negativeDirectionRequestN && !brakingRampStop && motorSpeed == '0
        && directionDelay == 16'h0002 |-> ##[1:24] (directionAck || brakingRampStop
        || positiveDirectionRequestN)) else $error("ack missing");
    a_dir_violation: assert property (directionAck && ((!positiveDirectionRequestN
        && negativeDirectionRequestN && $past(negativeDirectionRequestN, 4) && motorSpeed < 0)
        || (positiveDirectionRequestN && $past(positiveDirectionRequestN, 4)
        && !negativeDirectionRequestN && motorSpeed > 0)) |-> ##[0:2] brakingRampStop)
        else $error("no stop on reversal");

    // ====================
    // increment monitor
    a_inc_overspeed: assert property (rangeAck && !incrementRequestN
        && speedRangeRequestN && $past(speedRangeRequestN, 4)
        && motorSpeed > $signed({1'b0, incrementSpeedLimit}) |-> ##[0:2] brakingRampStop)
        else $error("no stop on overspeed");
endmodule

bind dim_monitor dim_monitor_sva #(.SPD_W(SPD_W), .TIME_W(TIME_W)) chk_u (
    .clk, .nrst, .positiveDirectionRequestN, .negativeDirectionRequestN, .incrementRequestN,
    .speedRangeRequestN, .motorSpeed, .directionDelay, .incrementSpeedLimit, .readyOut,
    .torqueOffAck, .brakingRampStop, .directionAck, .rangeAck, .standstillAck
);

// file: dv/dim_ctrl_model.sv
`timescale 1ns/100ps
module dim_ctrl_model (
    // clock
    input  wire logic       clk,
    // activation pins, active low
    output logic      [3:0] reqN,
    output logic            stopReqN,
    output logic            levelResetIn
);
    initial begin
        reqN         = 4'hF;
        stopReqN     = 1'b1;
        levelResetIn = 1'b1;
    end
    task automatic request(input int idx);
        @(negedge clk);
        reqN[idx] = 1'b0;
    endtask
    task automatic release_pin(input int idx);
        @(negedge clk);
        reqN[idx] = 1'b1;
    endtask
    task automatic change_dir(input int newIdx, input int oldIdx, input logic zeroDelay);
        if (zeroDelay) begin
            release_pin(oldIdx);
            repeat (4) @(negedge clk);
            request(newIdx);
        end else begin
            request(newIdx);
            repeat (4) @(negedge clk);
            release_pin(oldIdx);
        end
    endtask
    task automatic clear_stop();
        @(negedge clk);
        levelResetIn = 1'b0;
        repeat (4) @(negedge clk);
        levelResetIn = 1'b1;
        repeat (4) @(negedge clk);
    endtask
    task automatic pulse_stop();
        @(negedge clk);
        stopReqN = 1'b0;
        repeat (6) @(negedge clk);
        stopReqN = 1'b1;
    endtask
endmodule

// file: dv/dim_monitor_tb_top.sv
`timescale 1ns/100ps
module dim_monitor_tb_top;
    typedef struct {int pin; logic signed [15:0] spd; logic [31:0] dlt; logic stp;} dim_row_type;
    // ====================
    // signals
    logic               clk = 1'b0;
    logic               nrst = 1'b0;
    logic         [3:0] reqN;
    logic               stopReqN;
    logic               levelResetIn;
    logic signed [31:0] motorPosition = '0;
    logic signed [15:0] motorSpeed = '0, speedMax = 16'sh0064, speedMin = -16'sh0064;
    logic        [15:0] directionDelay = 16'h0002, standstillLimit = 16'h0002;
    logic        [15:0] incrementDelay = 16'h0002, incrementSpeedLimit = 16'h0032;
    logic        [15:0] speedRangeDelay = 16'h0001, standstillTime = 16'h0002;
    logic         [3:0] opt = 4'h0;
    logic               readyOut, torqueOffAck, brakingRampStop;
    logic               directionAck, rangeAck, standstillAck;
    int                 mismatches = 0;
    int                 cmp_count = 0;
    dim_row_type        rows [9] = '{'{0, 16'sh000A, 32'h0, 1'b0}, '{0, -16'sh000A, 32'h0, 1'b1},
        '{1, -16'sh000A, 32'h0, 1'b0}, '{1, 16'sh000A, 32'h0, 1'b1},
        '{2, 16'sh000A, 32'h64, 1'b0}, '{2, 16'sh000A, 32'h65, 1'b1},
        '{2, 16'sh0033, 32'h0, 1'b1}, '{3, 16'sh0064, 32'h0, 1'b0}, '{3, -16'sh0065, 32'h0, 1'b1}};

    always #50 clk = ~clk;
    dim_ctrl_model ctrl_u (.clk, .reqN, .stopReqN, .levelResetIn);
    dim_monitor #(.TICK_CYCLES(4)) dut_u (
        .clk, .nrst, .motorPosition, .motorSpeed, .directionDelay, .incrementDelay,
        .speedRangeDelay, .positiveDirectionRequestN(reqN[0]), .negativeDirectionRequestN(reqN[1]),
        .incrementRequestN(reqN[2]), .speedRangeRequestN(reqN[3]), .rampStopRequestN(stopReqN),
        .integrityLevelResetIn(levelResetIn), .standstillTime,
        .toleranceTime(16'h0003), .tolerancePeriod(16'h0004), .maxIncrement(32'h64),
        .incrementSpeedLimit, .standstillLimit, .standstillWindow(32'h5),
        .checkStandstill(opt[0]), .autoReactivate(opt[1]), .standstillWindowEn(opt[2]),
        .toleranceEn(opt[3]), .speedMax, .speedMin,
        .tolerancePercent(7'h14), .readyOut, .torqueOffAck, .brakingRampStop, .directionAck,
        .rangeAck, .standstillAck
    );
    // ====================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        cmp_count++;
        if (seen !== expv) begin
            mismatches++;
            $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, expv);
        end
    endtask
    function automatic logic ack_of(input int sel);
        return sel == 0 ? directionAck : (sel == 1 ? rangeAck : standstillAck);
    endfunction
    task automatic wait_ack(input int sel);
        int n = 0;
        while (ack_of(sel) !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ====================
    // tests
    initial begin
        settle(10);
        check({readyOut, brakingRampStop, torqueOffAck, directionAck, rangeAck, standstillAck},
              32'h20);
        $display("reset done");
        settle(2);
        nrst = 1'b1;
        foreach (rows[i]) begin
            ctrl_u.clear_stop();
            ctrl_u.request(rows[i].pin);
            wait_ack(rows[i].pin / 2);
            check(ack_of(rows[i].pin / 2), 1'b1);
            motorSpeed = rows[i].spd;
            motorPosition = motorPosition + rows[i].dlt;
            settle(6);
            check({brakingRampStop, readyOut}, {rows[i].stp, !rows[i].stp});
            motorSpeed = '0;
            settle(2);
            check(torqueOffAck, rows[i].stp);
            ctrl_u.release_pin(rows[i].pin);
            $display("row %0d done", i);
        end
        ctrl_u.clear_stop();
        ctrl_u.request(0);
        wait_ack(0);
        ctrl_u.change_dir(1, 0, 1'b0);
        check(directionAck, 1'b0);
        motorSpeed = -16'sh000A;
        wait_ack(0);
        check({brakingRampStop, directionAck}, 2'h1);
        motorSpeed = '0;
        directionDelay = '0;
        ctrl_u.change_dir(0, 1, 1'b1);
        wait_ack(0);
        check({brakingRampStop, directionAck}, 2'h1);
        ctrl_u.request(1);
        settle(8);
        check(brakingRampStop, 1'b1);
        ctrl_u.release_pin(0);
        ctrl_u.release_pin(1);
        directionDelay = 16'h0002;
        ctrl_u.clear_stop();
        ctrl_u.pulse_stop();
        check({brakingRampStop, readyOut}, 2'h2);
        ctrl_u.clear_stop();
        check({brakingRampStop, readyOut}, 2'h1);
        $display("direction done");
        opt = 4'h1;
        motorSpeed = 16'sh000A;
        ctrl_u.request(2);
        settle(16);
        check(brakingRampStop, 1'b1);
        ctrl_u.release_pin(2);
        motorSpeed = '0;
        opt = 4'h6;
        incrementDelay = 16'h0001;
        ctrl_u.clear_stop();
        ctrl_u.request(2);
        wait_ack(1);
        motorPosition = motorPosition + 32'h14;
        wait_ack(2);
        check({rangeAck, standstillAck}, 2'h1);
        wait_ack(1);
        check({rangeAck, standstillAck}, 2'h2);
        motorPosition = motorPosition + 32'h14;
        wait_ack(2);
        motorPosition = motorPosition + 32'h0A;
        settle(4);
        check(brakingRampStop, 1'b1);
        ctrl_u.release_pin(2);
        $display("increment done");
        opt = 4'h8;
        speedRangeDelay = 16'h0003;
        ctrl_u.clear_stop();
        ctrl_u.request(3);
        wait_ack(1);
        motorSpeed = 16'sh0073;
        settle(4);
        motorSpeed = 16'sh0032;
        settle(2);
        motorSpeed = -16'sh0073;
        settle(4);
        check(brakingRampStop, 1'b0);
        motorSpeed = -16'sh007D;
        settle(4);
        check(brakingRampStop, 1'b1);
        $display("tolerance done");
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule
